// [common/svm_pkg.sv]
package svm_pkg;
   // ==========================================
   // Register map and field positions
   // ==========================================
   localparam logic [19:0] CTRL_ADDR = 20'hFFFA9;
   localparam logic [19:0] LEVEL_ADDR = 20'hFFFAA;
   localparam int REW_EN_BIT = 7;
   localparam int MASK_BIT = 1;
   localparam int FLAG_BIT = 0;
   localparam int BEH_BIT = 7;
   localparam int THR_BIT = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] LVL_RST_COMB = 8'h00;
   localparam logic [7:0] LVL_RST_RSTM = 8'h81;
   localparam logic [7:0] LVL_RST_INTM = 8'h01;
   localparam logic [7:0] RD_NONE = 8'h00;

   // ==========================================
   // Configuration byte layout
   // ==========================================
   localparam int CFG_MODE_LO = 0;
   localparam int CFG_LEVEL_LO = 2;
   localparam int CFG_RANGE_HI = 7;
   localparam logic [1:0] CFG_COMB = 2'h2;
   localparam logic [1:0] CFG_RSTM = 2'h3;
   localparam logic [1:0] CFG_INTM = 2'h1;
   localparam int LEVEL_COUNT = 10;

   // ==========================================
   // Timing
   // ==========================================
   localparam int CLK_NS = 50;
   localparam int SETTLE_NS = 300;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {SVM_OFF, SVM_COMB, SVM_RSTM, SVM_INTM} svm_mode_t;
endpackage : svm_pkg

// [rtl/svm_ctrl.sv]
// Behaviour
// - Mode from config bits: 10,11,01
// - Threshold level chosen from config byte
// - Combined: irq below high, reset below low
// - Reset mode: reset while below single level
// - Interrupt mode: hold reset, then crossing irqs
// - Control bit 0 shows below-level state
// - Monitor reset sets reset-cause bit 0
// - Control clears unless monitor caused reset
// - Control bits 0 and 1 read-only
// - Control bit 7 gates level writes, masks
// - Mask flag only in combined mode
// - Level bit 7 behaviour, bit 0 threshold
// - Bit and byte writes both accepted
// - Level bit 0 one selects low level
// - Level reset value depends on mode
// - Combined mode auto-switches level bits
module svm_ctrl import svm_pkg::*; #(
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] cfg_byte,
   input wire logic cmp_below_high,
   input wire logic cmp_below_low,
   input wire logic [19:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_bit_op,
   input wire logic [2:0] reg_bit_sel,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic cause_clear,
   output logic [7:0] reg_rdata,
   output logic monitor_reset_req,
   output logic undervoltage_irq,
   output logic monitor_reset_cause,
   output logic [3:0] threshold_code
);
   // ==========================================
   // State
   // ==========================================
   typedef struct packed {
      logic s1_hi;
      logic s2_hi;
      logic p_hi;
      logic s1_lo;
      logic s2_lo;
      logic p_lo;
      svm_mode_t mode;
      logic [3:0] thr_code;
      logic rew_en;
      logic beh;
      logic thr;
      logic [7:0] settle;
      logic rst_req;
      logic irq;
      logic cause;
      logic [7:0] rdata;
   } svm_state_t;

   svm_state_t st;
   svm_state_t next_st;

   // Single-bit writes touch one position, byte writes all eight
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic bit_op, input logic [2:0] sel);
      logic [7:0] res;
      res = old;
      if (bit_op) begin
         res[sel] = wd[sel];
      end else begin
         res = wd;
      end
      return res;
   endfunction

   // Mode decode of the two config bits when bit 7 is clear; anything else is monitor off
   function automatic svm_mode_t decode_mode(input logic [7:0] cfg);
      svm_mode_t m;
      m = SVM_OFF;
      if (!cfg[CFG_RANGE_HI]) begin
         case (cfg[CFG_MODE_LO +: 2])
            CFG_COMB: m = SVM_COMB;
            CFG_RSTM: m = SVM_RSTM;
            CFG_INTM: m = SVM_INTM;
            default: m = SVM_OFF;
         endcase
      end
      return m;
   endfunction

   logic masked;
   logic below_sel;
   logic mon_rst;
   logic ctrl_hit;
   logic level_hit;
   logic [7:0] ctrl_view;
   logic [7:0] level_view;
   logic [7:0] wr_val;

   // ==========================================
   // Derived views
   // ==========================================
   // A reset while our own request is high is a monitor reset
   assign mon_rst = rst && st.rst_req;
   assign masked = (st.mode == SVM_COMB) && (st.rew_en || st.settle != 8'h00);
   // Combined mode watches the selected level, reset and interrupt modes the single one, off mode none
   assign below_sel = (st.mode == SVM_OFF) ? 1'b0 :
                      (st.mode == SVM_COMB && !st.thr) ? st.s2_hi : st.s2_lo;
   assign ctrl_hit = reg_addr == CTRL_ADDR;
   assign level_hit = reg_addr == LEVEL_ADDR;
   assign ctrl_view = {st.rew_en, 5'h00, masked, below_sel};
   assign level_view = {st.beh, 6'h00, st.thr};

   // ==========================================
   // Next-state logic
   // ==========================================
   // The monitor keeps running through its own reset; any other reset
   // restarts it from the config byte.
   always_comb begin
      next_st = st;
      wr_val = 8'h00;
      // Only the second stage and the previous-value flop feed logic, the first is never read elsewhere
      next_st.s1_hi = cmp_below_high;
      next_st.s2_hi = st.s1_hi;
      next_st.p_hi = st.s2_hi;
      next_st.s1_lo = cmp_below_low;
      next_st.s2_lo = st.s1_lo;
      next_st.p_lo = st.s2_lo;
      next_st.irq = 1'b0;
      if (st.settle != 8'h00) begin
         next_st.settle = st.settle - 8'h01;
      end

      // Register reads answer one cycle later; unmapped reads give zero
      next_st.rdata = RD_NONE;
      if (reg_rd && ctrl_hit) begin
         next_st.rdata = ctrl_view;
      end else if (reg_rd && level_hit) begin
         next_st.rdata = level_view;
      end

      // Control writes: only the rewrite enable, only in combined mode
      if (reg_wr && ctrl_hit && st.mode == SVM_COMB) begin
         wr_val = merge(ctrl_view, reg_wdata, reg_bit_op, reg_bit_sel);
         next_st.rew_en = wr_val[REW_EN_BIT];
      end
      // Level writes need the rewrite enable and combined mode
      if (reg_wr && level_hit && st.rew_en && st.mode == SVM_COMB) begin
         wr_val = merge(level_view, reg_wdata, reg_bit_op, reg_bit_sel);
         next_st.beh = wr_val[BEH_BIT];
         next_st.thr = wr_val[THR_BIT];
         if (wr_val[THR_BIT] != st.thr) begin
            next_st.settle = 8'(SETTLE_CYCLES);
         end
      end

      // Mode behaviour
      case (st.mode)
         SVM_COMB: begin
            if (st.s2_hi && !st.p_hi && !st.beh && !masked) begin
               next_st.irq = 1'b1;
               // Switch to low-level reset watching and let it settle
               next_st.beh = 1'b1;
               next_st.thr = 1'b1;
               next_st.settle = 8'(SETTLE_CYCLES);
            end
            if (st.s2_lo && !masked) begin
               next_st.rst_req = 1'b1;
            end else if (!st.s2_hi && st.rst_req) begin
               next_st.rst_req = 1'b0;
               // Back to high-level interrupt watching after the reset
               next_st.beh = 1'b0;
               next_st.thr = 1'b0;
               next_st.settle = 8'(SETTLE_CYCLES);
            end
         end
         SVM_RSTM: begin
            next_st.rst_req = st.s2_lo;
         end
         SVM_INTM: begin
            if (st.rst_req) begin
               next_st.rst_req = st.s2_lo;
               // Leaving the held reset is itself a rising crossing
               next_st.irq = !st.s2_lo;
            end else begin
               next_st.irq = st.s2_lo ^ st.p_lo;
            end
         end
         default: begin
            next_st.rst_req = 1'b0;
         end
      endcase

      // Cause flag: an asserted reset request wins over a clear
      if (next_st.rst_req) begin
         next_st.cause = 1'b1;
      end else if (cause_clear) begin
         next_st.cause = 1'b0;
      end

      // Non-monitor reset: reload from the config byte
      if (rst && !mon_rst) begin
         // Comparator flops keep tracking: zeroing them would read as supply
         // above level and let interrupt mode drop its held reset at once
         next_st.mode = decode_mode(cfg_byte);
         next_st.thr_code = {cfg_byte[CFG_RANGE_HI -: 2], cfg_byte[CFG_LEVEL_LO +: 2]};
         next_st.rew_en = CTRL_RST[REW_EN_BIT];
         next_st.settle = 8'h00;
         next_st.irq = 1'b0;
         next_st.cause = 1'b0;
         next_st.rdata = RD_NONE;
         // Interrupt mode holds its reset after any non-monitor reset
         next_st.rst_req = decode_mode(cfg_byte) == SVM_INTM;
         case (decode_mode(cfg_byte))
            SVM_COMB: begin
               next_st.beh = LVL_RST_COMB[BEH_BIT];
               next_st.thr = LVL_RST_COMB[THR_BIT];
            end
            SVM_RSTM: begin
               next_st.beh = LVL_RST_RSTM[BEH_BIT];
               next_st.thr = LVL_RST_RSTM[THR_BIT];
            end
            default: begin
               next_st.beh = LVL_RST_INTM[BEH_BIT];
               next_st.thr = LVL_RST_INTM[THR_BIT];
            end
         endcase
      end
   end

   // ==========================================
   // State register
   // ==========================================
   always_ff @(posedge clock) begin
      st <= next_st;
   end

   // Outputs straight from flops
   assign reg_rdata = st.rdata;
   assign monitor_reset_req = st.rst_req;
   assign undervoltage_irq = st.irq;
   assign monitor_reset_cause = st.cause;
   assign threshold_code = st.thr_code;

   // ==========================================
   // Checks
   // ==========================================
   sequence comb_fall_s;
      st.mode == SVM_COMB && st.s2_hi && !st.p_hi && !st.beh && !masked;
   endsequence

   sequence irq_switch_s;
      undervoltage_irq && st.beh && st.thr && st.settle != 8'h00;
   endsequence

   comb_irq_a: assert property (@(posedge clock) disable iff (rst)
      comb_fall_s |=> irq_switch_s)
      else $error("combined irq or level switch missing");

   comb_rst_a: assert property (@(posedge clock) disable iff (rst)
      (st.mode == SVM_COMB && st.s2_lo && !masked) |=> monitor_reset_req)
      else $error("combined reset not raised");

   rstm_follow_a: assert property (@(posedge clock) disable iff (rst)
      st.mode == SVM_RSTM |=> monitor_reset_req == $past(st.s2_lo))
      else $error("reset mode request wrong");

   intm_cross_a: assert property (@(posedge clock) disable iff (rst)
      (st.mode == SVM_INTM && !st.rst_req && $changed(st.p_lo) == 1'b0 && (st.s2_lo != st.p_lo))
      |=> undervoltage_irq)
      else $error("interrupt mode crossing lost");

   flag_read_a: assert property (@(posedge clock) disable iff (rst)
      (reg_rd && ctrl_hit) |=> reg_rdata[FLAG_BIT] == $past(below_sel)
      && reg_rdata[6:2] == 5'h00)
      else $error("control readback wrong");

   cause_set_a: assert property (@(posedge clock) disable iff (rst)
      monitor_reset_req |-> monitor_reset_cause)
      else $error("reset cause not set");

   mask_mode_a: assert property (@(posedge clock) disable iff (rst)
      st.mode != SVM_COMB |-> !masked && !st.rew_en)
      else $error("mask outside combined mode");

   lvl_guard_a: assert property (@(posedge clock) disable iff (rst)
      (reg_wr && level_hit && !st.rew_en && !st.rst_req && st.s2_hi == st.p_hi)
      |=> st.beh == $past(st.beh) && st.thr == $past(st.thr))
      else $error("level changed without enable");

   rst_load_a: assert property (@(posedge clock)
      (rst && !st.rst_req && decode_mode(cfg_byte) == SVM_RSTM)
      |=> st.beh && st.thr && !st.rew_en)
      else $error("reset value wrong");

   sync_lat_a: assert property (@(posedge clock) disable iff (rst)
      $rose(cmp_below_low) ##1 cmp_below_low |=> st.s2_lo)
      else $error("synchroniser latency wrong");
endmodule // svm_ctrl

// [verification/svm_ctrl_bench.sv]
module svm_ctrl_bench import svm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(what, exp, act) begin \
   checked++; \
   if ((act) !== (exp)) begin \
      mismatches++; \
      $display("wrong value %s expected %h seen %h", what, exp, act); \
   end \
end
   // ==========================================
   // Stimulus, design and bookkeeping
   // ==========================================
   logic clock = 1'b0, rst = 1'b1, cmp_below_high = 1'b0, cmp_below_low = 1'b0;
   logic reg_wr = 1'b0, reg_bit_op = 1'b0, reg_rd = 1'b0, cause_clear = 1'b0;
   logic [7:0] cfg_byte = 8'h3A, reg_wdata = 8'h00, reg_rdata, rd_val;
   logic [19:0] reg_addr = 20'h00000;
   logic [2:0] reg_bit_sel = 3'h0;
   logic monitor_reset_req, undervoltage_irq, monitor_reset_cause;
   logic [3:0] threshold_code;
   int mismatches = 0, checked = 0, cycles = 0, pulses;
   svm_ctrl #(.SETTLE_CYCLES(2)) u_svm_ctrl (.clock(clock), .rst(rst), .cfg_byte(cfg_byte),
      .cmp_below_high(cmp_below_high), .cmp_below_low(cmp_below_low), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_bit_op(reg_bit_op), .reg_bit_sel(reg_bit_sel), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .cause_clear(cause_clear), .reg_rdata(reg_rdata),
      .monitor_reset_req(monitor_reset_req), .undervoltage_irq(undervoltage_irq),
      .monitor_reset_cause(monitor_reset_cause), .threshold_code(threshold_code));
   // Clock and a hang guard well above the expected run length
   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end
   // ==========================================
   // Shared bus and wait tasks
   // ==========================================
   task automatic do_reset(input logic [7:0] cfg);
      @(posedge clock);
      cfg_byte <= cfg;
      rst <= 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
   endtask
   task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic bop, input logic [2:0] sel);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_bit_op <= bop;
      reg_bit_sel <= sel;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Read data is registered, so it is taken just after the edge that follows the strobe
   task automatic rd(input logic [19:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   task automatic irq_count(input int n);
      pulses = 0;
      repeat (n) begin
         @(posedge clock);
         #1 if (undervoltage_irq === 1'b1) pulses++;
      end
   endtask
   // Comparator levels change only on a rising edge, like every other input
   task automatic set_cmp(input logic hi, input logic lo);
      @(posedge clock);
      cmp_below_high <= hi;
      cmp_below_low <= lo;
   endtask
   // Bounded wait for the reset request to reach a level
   task automatic wait_req(input logic v);
      for (int i = 0; i < 12 && monitor_reset_req !== v; i++) @(posedge clock);
      #1 `CHK("reset request", v, monitor_reset_req)
   endtask
   // ==========================================
   // Scenarios
   // ==========================================
   task automatic combined_registers();
      do_reset(8'h3A);
      rd(CTRL_ADDR); `CHK("control after reset", CTRL_RST, rd_val)
      rd(LEVEL_ADDR); `CHK("level after reset", LVL_RST_COMB, rd_val)
      `CHK("threshold code", 4'h2, threshold_code)
      wr(CTRL_ADDR, 8'hFF, 1'b0, 3'h0);
      rd(CTRL_ADDR); `CHK("control read-only bits", 8'h82, rd_val)
      wr(LEVEL_ADDR, 8'h81, 1'b0, 3'h0);
      wr(LEVEL_ADDR, 8'h00, 1'b1, 3'h7);
      rd(LEVEL_ADDR); `CHK("level bit write", 8'h01, rd_val)
      // Mask must swallow a drop below the high level while rewrite is enabled
      wr(LEVEL_ADDR, 8'h00, 1'b0, 3'h0);
      set_cmp(1'b1, 1'b0);
      irq_count(8); `CHK("masked irq count", 0, pulses)
      set_cmp(1'b0, 1'b0);
      irq_count(4);
      wr(CTRL_ADDR, 8'h00, 1'b1, 3'h7);
      wr(LEVEL_ADDR, 8'h01, 1'b0, 3'h0);
      rd(LEVEL_ADDR); `CHK("level write blocked", 8'h00, rd_val)
      rd(20'h00100); `CHK("unmapped read", RD_NONE, rd_val)
   endtask
   task automatic combined_monitor_reset();
      set_cmp(1'b1, 1'b0);
      irq_count(8); `CHK("irq below high", 1, pulses)
      rd(LEVEL_ADDR); `CHK("level auto switch", 8'h81, rd_val)
      set_cmp(1'b1, 1'b1);
      wait_req(1'b1);
      `CHK("reset cause", 1'b1, monitor_reset_cause)
      do_reset(8'h3A);
      rd(LEVEL_ADDR); `CHK("level kept", 8'h81, rd_val)
      rd(CTRL_ADDR); `CHK("control kept", 8'h01, rd_val)
      set_cmp(1'b0, 1'b0);
      wait_req(1'b0);
      rd(LEVEL_ADDR); `CHK("level switched back", 8'h00, rd_val)
      @(posedge clock);
      cause_clear <= 1'b1;
      @(posedge clock);
      cause_clear <= 1'b0;
      #1 `CHK("cause cleared", 1'b0, monitor_reset_cause)
   endtask
   task automatic reset_mode();
      do_reset(8'h3F);
      rd(LEVEL_ADDR); `CHK("reset mode level", LVL_RST_RSTM, rd_val)
      `CHK("threshold code", 4'h3, threshold_code)
      wr(CTRL_ADDR, 8'h80, 1'b0, 3'h0);
      rd(CTRL_ADDR); `CHK("rewrite outside combined", 8'h00, rd_val)
      set_cmp(1'b0, 1'b1);
      wait_req(1'b1);
      set_cmp(1'b0, 1'b0);
      wait_req(1'b0);
   endtask
   task automatic interrupt_mode();
      set_cmp(1'b0, 1'b1);
      do_reset(8'h3D);
      rd(LEVEL_ADDR); `CHK("int mode level", LVL_RST_INTM, rd_val)
      `CHK("held reset", 1'b1, monitor_reset_req)
      set_cmp(1'b0, 1'b0);
      irq_count(8); `CHK("release crossing irq", 1, pulses)
      `CHK("reset released", 1'b0, monitor_reset_req)
      set_cmp(1'b0, 1'b1);
      irq_count(8); `CHK("falling crossing irq", 1, pulses)
      rd(CTRL_ADDR); `CHK("below level flag", 8'h01, rd_val)
   endtask
   // ==========================================
   // Main sequence and verdict
   // ==========================================
   task automatic results();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      combined_registers();
      combined_monitor_reset();
      reset_mode();
      interrupt_mode();
      results();
   end
endmodule // svm_ctrl_bench
